/* File: logic/pegq_defines.vh */
// constants for the port egress queue and shaper register bank
`ifndef PEGQ_DEFINES_VH
`define PEGQ_DEFINES_VH
// register indexes within a port block; byte address is four times the index
`define PEGQ_IDX_QUEUE_INDEX 12'h900
`define PEGQ_IDX_QUEUE_CTRL0 12'h914
`define PEGQ_IDX_RR_WEIGHT 12'h915
`define PEGQ_IDX_CREDIT_HIGH 12'h916
`define PEGQ_IDX_CREDIT_LOW 12'h918
`define PEGQ_IDX_CREDIT_INCR 12'h91A
`define PEGQ_IDX_PORT_CTRL0 12'hA00
`define PEGQ_IDX_FWD_MEMBER 12'hA04
`define PEGQ_IDX_TXQ_MEMORY 12'hA10
// reset values
`define PEGQ_RST_WEIGHT 7'h01
`define PEGQ_RST_HIGH 16'h0534
`define PEGQ_RST_LOW 16'h05F2
`define PEGQ_RST_INCR 16'h2000
`define PEGQ_RST_MEMBER 3'h7
`define PEGQ_RST_SCHED 2'h2
`define PEGQ_RST_SHAPER 2'h0
`define PEGQ_RST_QIDX 2'h0
// field positions in queue control 0
`define PEGQ_SCHED_HI 7
`define PEGQ_SCHED_LO 6
`define PEGQ_SHAPER_HI 5
`define PEGQ_SHAPER_LO 4
// mode encodings
`define PEGQ_SCHED_WRR 2'h2
`define PEGQ_SHAPER_CBS 2'h1
// credit fixed point: fraction bits
`define PEGQ_FRAC_BITS 16
// block count limit
`define PEGQ_BLK_MAX 11'h7FF
// AXI responses
`define PEGQ_RESP_OKAY 2'h0
`define PEGQ_RESP_SLVERR 2'h2
`endif

/* File: logic/pegq_port_engine.v */
// per-port egress scheduler, credit shaper and transmit block counter
`include "pegq_defines.vh"
module pegq_port_engine (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // configuration
  input wire [1:0] sched_mode,
  input wire [7:0] shaper_mode,
  input wire [27:0] weight,
  input wire [63:0] high_limit,
  input wire [63:0] low_limit,
  input wire [63:0] incr,
  // queue status
  input wire [3:0] q_pending,
  input wire tx_done,
  input wire [15:0] tx_bytes,
  input wire blk_alloc,
  input wire blk_free,
  // results
  output reg grant_valid,
  output reg [1:0] grant_queue,
  output reg [10:0] block_count
);
  reg signed [33:0] credit [0:3];
  reg signed [33:0] next_credit [0:3];
  reg signed [34:0] t;
  reg [3:0] eligible;
  reg [1:0] cur_q;
  reg [6:0] pkt_cnt;
  reg [6:0] wt;
  reg [1:0] start;
  reg [1:0] pick;
  reg [1:0] cand;
  reg found;
  // one loop index per process, so that no process wakes another through it
  integer i;
  integer j;
  integer k;

  always @* begin
    t = 35'sh0;
    for (i = 0; i < 4; i = i + 1) begin
      t = {credit[i][33], credit[i]};
      if (shaper_mode[2*i+:2] == `PEGQ_SHAPER_CBS) begin
        // credit grows while waiting, drops by bytes sent
        if (q_pending[i] && !(grant_valid && grant_queue == i[1:0]))
          t = t + $signed({19'h0, incr[16*i+:16]});
        if (tx_done && grant_valid && grant_queue == i[1:0])
          t = t - $signed({3'h0, tx_bytes, 16'h0});
        if (t > $signed({3'h0, high_limit[16*i+:16], 16'h0}))
          t = $signed({3'h0, high_limit[16*i+:16], 16'h0});
        if (t < -$signed({3'h0, low_limit[16*i+:16], 16'h0}))
          t = -$signed({3'h0, low_limit[16*i+:16], 16'h0});
      end else begin
        t = 35'sh0;
      end
      next_credit[i] = t[33:0];
      // shaper gates only in credit mode
      eligible[i] = q_pending[i] &&
        (shaper_mode[2*i+:2] != `PEGQ_SHAPER_CBS || !credit[i][33]);
    end
  end

  always @* begin
    wt = (weight[7*cur_q+:7] == 7'h0) ? 7'h1 : weight[7*cur_q+:7];
    found = 1'b0;
    pick = 2'h0;
    cand = 2'h0;
    if (sched_mode == `PEGQ_SCHED_WRR) begin
      // stay on the queue until its weight is spent, then move on in turn
      start = (pkt_cnt < wt && eligible[cur_q]) ? cur_q : cur_q + 2'h1;
      for (j = 0; j < 4; j = j + 1) begin
        cand = start + j[1:0];
        if (!found && eligible[cand]) begin
          found = 1'b1;
          pick = cand;
        end
      end
    end else begin
      start = 2'h3;
      for (j = 3; j >= 0; j = j - 1) begin
        if (!found && eligible[j]) begin
          found = 1'b1;
          pick = j[1:0];
        end
      end
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      for (k = 0; k < 4; k = k + 1) begin
        credit[k] <= 34'sh0;
      end
      grant_valid <= 1'b0;
      grant_queue <= 2'h0;
      cur_q <= 2'h0;
      pkt_cnt <= 7'h0;
      block_count <= 11'h0;
    end else begin
      for (k = 0; k < 4; k = k + 1) begin
        credit[k] <= next_credit[k];
      end
      if (grant_valid) begin
        if (tx_done)
          grant_valid <= 1'b0;
      end else if (found) begin
        grant_valid <= 1'b1;
        grant_queue <= pick;
        cur_q <= pick;
        pkt_cnt <= (pick == cur_q && pkt_cnt != 7'h7F) ? pkt_cnt + 7'h1 : 7'h1;
      end
      // idle port reports zero blocks unless a block is allocated in the same cycle
      if (q_pending == 4'h0 && !blk_alloc)
        block_count <= 11'h0;
      else if (blk_alloc && !blk_free && block_count != `PEGQ_BLK_MAX)
        block_count <= block_count + 11'h1;
      else if (blk_free && !blk_alloc && block_count != 11'h0)
        block_count <= block_count - 11'h1;
    end
  end
endmodule

/* File: logic/pegq_regs.v */
// egress queue, shaper and forwarding register bank for three switch ports
`include "pegq_defines.vh"
module pegq_regs (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // AXI4-Lite write address
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // per-port queue status, three ports packed
  input wire [11:0] q_pending,
  input wire [2:0] tx_done,
  input wire [47:0] tx_bytes,
  input wire [2:0] blk_alloc,
  input wire [2:0] blk_free,
  // per-port results
  output reg [8:0] port_fwd_mask,
  output wire [2:0] sched_grant_valid,
  output wire [5:0] sched_grant_queue
);
  reg [1:0] qidx [0:2];
  reg [1:0] sched [0:11];
  reg [1:0] shaper [0:11];
  reg [6:0] weight [0:11];
  reg [15:0] high [0:11];
  reg [15:0] low [0:11];
  reg [15:0] incr [0:11];
  reg [15:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  wire [32:0] count_bus;
  wire [10:0] blocks [0:2];

  // write address decode
  reg [13:0] widx;
  reg [1:0] wport;
  reg [3:0] wslot;
  reg wok;
  // read address decode
  reg [13:0] ridx;
  reg [1:0] rport;
  reg [3:0] rslot;
  reg rok;
  reg [31:0] rval;
  // write target decode
  reg wr_qidx;
  reg wr_ctrl0;
  reg wr_weight;
  reg wr_high;
  reg wr_low;
  reg wr_incr;
  reg wr_member;
  reg wr_legal;
  reg [31:0] wold;
  reg [31:0] wnew;
  integer i;

  // merge byte lanes of a write into the current value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b])
          merge[8*b+:8] = data[8*b+:8];
      end
    end
  endfunction

  always @* begin
    widx = aw_addr[15:2];
    wport = widx[13:12] - 2'h1;
    wok = (widx[13:12] != 2'h0);
    wslot = {wport, qidx[wport]};
    ridx = s_axi_araddr[15:2];
    rport = ridx[13:12] - 2'h1;
    rok = (ridx[13:12] != 2'h0);
    rslot = {rport, qidx[rport]};
    rval = 32'h0;
    if (!rok) begin
      rok = 1'b0;
    end else if (ridx[11:0] == `PEGQ_IDX_QUEUE_INDEX) begin
      rval = {30'h0, qidx[rport]};
    end else if (ridx[11:0] == `PEGQ_IDX_QUEUE_CTRL0) begin
      rval = {24'h0, sched[rslot], shaper[rslot], 4'h0};
    end else if (ridx[11:0] == `PEGQ_IDX_RR_WEIGHT) begin
      rval = {25'h0, weight[rslot]};
    end else if (ridx[11:0] == `PEGQ_IDX_CREDIT_HIGH) begin
      rval = {16'h0, high[rslot]};
    end else if (ridx[11:0] == `PEGQ_IDX_CREDIT_LOW) begin
      rval = {16'h0, low[rslot]};
    end else if (ridx[11:0] == `PEGQ_IDX_CREDIT_INCR) begin
      rval = {16'h0, incr[rslot]};
    end else if (ridx[11:0] == `PEGQ_IDX_PORT_CTRL0) begin
      rval = 32'h0;
    end else if (ridx[11:0] == `PEGQ_IDX_FWD_MEMBER) begin
      rval = {29'h0, port_fwd_mask[3*rport+:3]};
    end else if (ridx[11:0] == `PEGQ_IDX_TXQ_MEMORY) begin
      rval = {21'h0, blocks[rport]};
    end else begin
      rok = 1'b0;
    end
  end

  // write decode: target of the held write and its value with byte lanes merged
  always @* begin
    wr_qidx = 1'b0;
    wr_ctrl0 = 1'b0;
    wr_weight = 1'b0;
    wr_high = 1'b0;
    wr_low = 1'b0;
    wr_incr = 1'b0;
    wr_member = 1'b0;
    wr_legal = 1'b1;
    wold = 32'h0;
    if (!wok) begin
      wr_legal = 1'b0;
    end else if (widx[11:0] == `PEGQ_IDX_QUEUE_INDEX) begin
      wr_qidx = 1'b1;
      wold = {30'h0, qidx[wport]};
    end else if (widx[11:0] == `PEGQ_IDX_QUEUE_CTRL0) begin
      // byte-wide registers change only when their lane is written
      wr_ctrl0 = w_strb[0];
    end else if (widx[11:0] == `PEGQ_IDX_RR_WEIGHT) begin
      wr_weight = w_strb[0];
    end else if (widx[11:0] == `PEGQ_IDX_CREDIT_HIGH) begin
      wr_high = 1'b1;
      wold = {16'h0, high[wslot]};
    end else if (widx[11:0] == `PEGQ_IDX_CREDIT_LOW) begin
      wr_low = 1'b1;
      wold = {16'h0, low[wslot]};
    end else if (widx[11:0] == `PEGQ_IDX_CREDIT_INCR) begin
      wr_incr = 1'b1;
      wold = {16'h0, incr[wslot]};
    end else if (widx[11:0] == `PEGQ_IDX_FWD_MEMBER) begin
      wr_member = w_strb[0];
    end else if (widx[11:0] == `PEGQ_IDX_PORT_CTRL0) begin
      // undefined word takes the write and drops it
      wr_legal = 1'b1;
    end else if (widx[11:0] == `PEGQ_IDX_TXQ_MEMORY) begin
      // read-only count ignores writes
      wr_legal = 1'b1;
    end else begin
      wr_legal = 1'b0;
    end
    wnew = merge(wold, w_data, w_strb);
  end

  // write path: address and data taken in either order, response after both
  always @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PEGQ_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 16'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      port_fwd_mask <= {3{`PEGQ_RST_MEMBER}};
      for (i = 0; i < 3; i = i + 1) begin
        qidx[i] <= `PEGQ_RST_QIDX;
      end
      for (i = 0; i < 12; i = i + 1) begin
        sched[i] <= `PEGQ_RST_SCHED;
        shaper[i] <= `PEGQ_RST_SHAPER;
        weight[i] <= `PEGQ_RST_WEIGHT;
        high[i] <= `PEGQ_RST_HIGH;
        low[i] <= `PEGQ_RST_LOW;
        incr[i] <= `PEGQ_RST_INCR;
      end
    end else begin
      s_axi_awready <= !aw_held && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_legal ? `PEGQ_RESP_OKAY : `PEGQ_RESP_SLVERR;
        if (wr_qidx)
          qidx[wport] <= wnew[1:0];
        if (wr_ctrl0) begin
          sched[wslot] <= w_data[`PEGQ_SCHED_HI:`PEGQ_SCHED_LO];
          shaper[wslot] <= w_data[`PEGQ_SHAPER_HI:`PEGQ_SHAPER_LO];
        end
        if (wr_weight)
          weight[wslot] <= w_data[6:0];
        if (wr_high)
          high[wslot] <= wnew[15:0];
        if (wr_low)
          low[wslot] <= wnew[15:0];
        if (wr_incr)
          incr[wslot] <= wnew[15:0];
        if (wr_member)
          port_fwd_mask[3*wport+:3] <= w_data[2:0];
      end
    end
  end

  // read path: one cycle from address handshake to data
  always @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `PEGQ_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rval;
        s_axi_rresp <= rok ? `PEGQ_RESP_OKAY : `PEGQ_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // one engine per port; settings of all four queues fed in parallel, except the scheduler mode, taken from queue 0 only
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_port
      // the engine sees all four queues of its port at once
      wire [7:0] shaper_pk;
      wire [27:0] weight_pk;
      wire [63:0] high_pk;
      wire [63:0] low_pk;
      wire [63:0] incr_pk;
      assign shaper_pk = {shaper[4*p+3], shaper[4*p+2], shaper[4*p+1], shaper[4*p]};
      assign weight_pk = {weight[4*p+3], weight[4*p+2], weight[4*p+1], weight[4*p]};
      assign high_pk = {high[4*p+3], high[4*p+2], high[4*p+1], high[4*p]};
      assign low_pk = {low[4*p+3], low[4*p+2], low[4*p+1], low[4*p]};
      assign incr_pk = {incr[4*p+3], incr[4*p+2], incr[4*p+1], incr[4*p]};
      pegq_port_engine u_engine (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .sched_mode(sched[4*p]),
        .shaper_mode(shaper_pk),
        .weight(weight_pk),
        .high_limit(high_pk),
        .low_limit(low_pk),
        .incr(incr_pk),
        .q_pending(q_pending[4*p+:4]),
        .tx_done(tx_done[p]),
        .tx_bytes(tx_bytes[16*p+:16]),
        .blk_alloc(blk_alloc[p]),
        .blk_free(blk_free[p]),
        .grant_valid(sched_grant_valid[p]),
        .grant_queue(sched_grant_queue[2*p+:2]),
        .block_count(count_bus[11*p+:11])
      );
      assign blocks[p] = count_bus[11*p+:11];
    end
  endgenerate
endmodule

/* File: verification/pegq_regs_props.sv */
// port-level assertions for the egress queue register bank
`include "pegq_defines.vh"
module pegq_regs_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register bus
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // queue status and results
  input wire logic [11:0] q_pending,
  input wire logic [2:0] tx_done,
  input wire logic [8:0] port_fwd_mask,
  input wire logic [2:0] sched_grant_valid,
  input wire logic [5:0] sched_grant_queue
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_take;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_mask_reset:
    assert property (disable iff (1'b0) sys_rst |=> port_fwd_mask == 9'h1FF)
    else $error("membership mask not restored by reset");
  a_grant_hold:
    assert property (sched_grant_valid[0] && !tx_done[0]
      |=> sched_grant_valid[0] && $stable(sched_grant_queue[1:0]))
    else $error("grant dropped or moved before send");
  a_grant_clear:
    assert property (sched_grant_valid[0] && tx_done[0] |=> !sched_grant_valid[0])
    else $error("grant kept after send");
  a_grant_waiting:
    assert property ($rose(sched_grant_valid[0]) |-> q_pending[sched_grant_queue[1:0]])
    else $error("grant to an empty queue");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer:
    assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_port_zero:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[15:14] == 2'h0
      |=> s_axi_rresp == `PEGQ_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("port zero read not refused");
  a_mask_follows:
    assert property (wr_take && s_axi_awaddr == 16'h6810 && s_axi_wstrb[0]
      |-> ##3 port_fwd_mask[2:0] == $past(s_axi_wdata[2:0], 3))
    else $error("membership write not applied");
  c_grant: cover property ($rose(sched_grant_valid[0]));
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == `PEGQ_RESP_SLVERR);
  c_write: cover property (wr_take);
endmodule
bind pegq_regs pegq_regs_props props_i (.*);

/* File: verification/pegq_regs_test.sv */
// self-checking bench for the egress queue register bank
`include "pegq_defines.vh"
module pegq_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {bit wr; logic [1:0] p; logic [11:0] o; logic [31:0] d; logic [1:0] rs;} pegq_row_t;
  localparam logic [1:0] ok = `PEGQ_RESP_OKAY;
  localparam logic [1:0] er = `PEGQ_RESP_SLVERR;
  logic core_clk = 0, sys_rst = 1;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, gq;
  logic [11:0] q_pending = 0;
  logic [2:0] tx_done = 0, blk_alloc = 0, blk_free = 0, sched_grant_valid;
  logic [47:0] tx_bytes = 0;
  logic [8:0] port_fwd_mask;
  logic [5:0] sched_grant_queue;
  int err_count = 0, samples_checked = 0, zeros;
  // queue 2 of port 1 and the port 1 membership are written; other queues and ports must keep defaults
  pegq_row_t rows [19] = '{
    '{1, 1, 12'h900, 32'h2, ok}, '{1, 1, 12'h916, 32'h1234, ok}, '{0, 1, 12'h916, 32'h1234, ok},
    '{1, 1, 12'h900, 32'h0, ok}, '{0, 1, 12'h916, 32'h0534, ok}, '{1, 2, 12'h900, 32'h2, ok},
    '{0, 2, 12'h916, 32'h0534, ok}, '{0, 2, 12'h918, 32'h05F2, ok}, '{0, 3, 12'h91A, 32'h2000, ok},
    '{0, 1, 12'h915, 32'h1, ok}, '{0, 3, 12'hA04, 32'h7, ok}, '{1, 1, 12'hA10, 32'h7FF, ok},
    '{0, 1, 12'hA10, 32'h0, ok}, '{1, 1, 12'hA04, 32'h5, ok}, '{0, 1, 12'hA04, 32'h5, ok},
    '{0, 0, 12'h916, 32'h0, er}, '{1, 1, 12'h917, 32'h0, er}, '{0, 1, 12'hA00, 32'h0, ok},
    '{0, 2, 12'h914, 32'h80, ok}};
  always #4 core_clk = ~core_clk;
  pegq_regs DUT (.*);
  function automatic logic [15:0] adr(input logic [1:0] p, input logic [11:0] o);
    return {p, o, 2'h0};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // np is the port 1 waiting set applied one cycle after the send is reported
  task automatic serve(input logic [3:0] np, output logic [1:0] q);
    do @(posedge core_clk); while (sched_grant_valid[0] !== 1'b1);
    q = sched_grant_queue[1:0];
    tx_done[0] <= 1;
    tx_bytes[15:0] <= 16'h0040;
    @(posedge core_clk);
    tx_done[0] <= 0;
    q_pending[3:0] <= np;
  endtask
  task automatic wrap_up;
    $display("mismatches %0d, checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 0;
    chk({23'h0, port_fwd_mask}, 32'h1FF);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(adr(rows[i].p, rows[i].o), rows[i].d, rs);
        chk({30'h0, rs}, {30'h0, rows[i].rs});
      end else begin
        rd(adr(rows[i].p, rows[i].o), rv, rs);
        chk(rv, rows[i].d);
        chk({30'h0, rs}, {30'h0, rows[i].rs});
      end
    end
    chk({23'h0, port_fwd_mask}, 32'h1FD);
    // strict priority on port 1: highest waiting queue wins
    wr(adr(1, 12'h900), 32'h0, rs);
    wr(adr(1, 12'h914), 32'h0, rs);
    q_pending[3:0] <= 4'h5;
    serve(4'h0, gq);
    chk({30'h0, gq}, 32'h2);
    // round robin with weight two on queue 0, one on queue 2
    wr(adr(1, 12'h914), 32'h80, rs);
    wr(adr(1, 12'h915), 32'h2, rs);
    q_pending[3:0] <= 4'h5;
    zeros = 0;
    for (int k = 0; k < 6; k++) begin
      serve(k == 5 ? 4'h0 : 4'h5, gq);
      zeros += (gq == 2'h0);
    end
    chk(zeros, 32'h4);
    // credit shaper on queue 3 of port 1: a sent packet leaves it in debt, queue 1 goes next
    wr(adr(1, 12'h900), 32'h0, rs);
    wr(adr(1, 12'h914), 32'h0, rs);
    wr(adr(1, 12'h900), 32'h3, rs);
    wr(adr(1, 12'h914), 32'h10, rs);
    q_pending[3:0] <= 4'hA;
    serve(4'hA, gq);
    chk({30'h0, gq}, 32'h3);
    serve(4'h0, gq);
    chk({30'h0, gq}, 32'h1);
    // port 2 block count: three taken, one freed, then queues empty
    q_pending[4] <= 1;
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      blk_alloc[1] <= (k < 3);
      blk_free[1] <= (k == 3);
    end
    @(posedge core_clk);
    blk_alloc[1] <= 0;
    blk_free[1] <= 0;
    rd(adr(2, 12'hA10), rv, rs);
    chk(rv, 32'h2);
    q_pending[4] <= 0;
    repeat (3) @(posedge core_clk);
    rd(adr(2, 12'hA10), rv, rs);
    chk(rv, 32'h0);
    // reset in mid run brings back defaults
    sys_rst <= 1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 0;
    rd(adr(1, 12'h915), rv, rs);
    chk(rv, 32'h1);
    rd(adr(1, 12'hA04), rv, rs);
    chk(rv, 32'h7);
    wrap_up;
  end
endmodule
